/* src/ldr_defines.svh */
`ifndef LDR_DEFINES_SVH
`define LDR_DEFINES_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define LDR_NCOLS      80
`define LDR_LAST_COL   7'h4F
`define LDR_NROWS      4
`define LDR_BANK_OFS   2'h2

// ----------------------------------------
// Drive mode codes
// ----------------------------------------
`define LDR_MODE_STAT  2'h1
`define LDR_MODE_MUX2  2'h2
`define LDR_MODE_MUX3  2'h3
`define LDR_MODE_MUX4  2'h0

// ----------------------------------------
// Pointer steps per byte
// ----------------------------------------
`define LDR_INC_STAT   8'h08
`define LDR_INC_MUX2   8'h04
`define LDR_INC_MUX3   8'h03
`define LDR_INC_MUX4   8'h02

// ----------------------------------------
// Command byte patterns
// ----------------------------------------
`define LDR_CMD_MODE   4'hC
`define LDR_CMD_DEV    5'h1C
`define LDR_CMD_BANK   6'h3E

`endif

/* src/ldr_display_ram.sv */
`timescale 1ns/1ps
`include "ldr_defines.svh"

// Overview of operation
// - 1:3 mode: fourth backplane copies second
// - 1:2 mode: third copies first, fourth second
// - Static: all backplanes share one waveform
// - Rows map to backplanes, columns to segments
// - Stored one turns element on
// - Static: byte fills row zero, eight columns
// - 1:2: byte becomes four two-bit columns
// - 1:3: three columns, last row bit untouched
// - 1:4: byte becomes two four-bit columns
// - Byte replaces its column slots fully
// - Data stored from column in pointer
// - Pointer advances 8, 4, 3 or 2
// - Write only when subaddress counter matches straps
// - Mismatch: no write, pointer still advances
// - Pointer overflow increments subaddress counter
// - Overflow handoff works inside one byte
// - Last device drops overflow bits, no ack
// - Readout row sequence depends on mode
// - Output bank shows rows two/three instead
// - Input bank redirects writes to rows two/three
// - Bank command 111110IO, ignored in 1:3/1:4
// - Pointer command: top bit clear, column
// - Subaddress command 11100 loads counter
// - Mode codes: 01 static, 10, 11, 00
module ldr_display_ram (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire ldr_pkg::ldr_byte_s  in_byte,
    input  wire logic                in_valid,
    output logic                     in_ready,
    input  wire logic                strap_sub_bit_lo,
    input  wire logic                strap_sub_bit_mid,
    input  wire logic                strap_sub_bit_hi,
    input  wire logic                cascade_last,
    input  wire logic                frame_clk,
    output ldr_pkg::ldr_mode_t       drive_mode,
    output logic                     byte_ack,
    output logic                     byte_nack,
    output ldr_pkg::ldr_bp_s         backplanes,
    output logic [79:0]              segment_outputs
);
    import ldr_pkg::*;

    // ----------------------------------------
    // Two-entry input buffer
    // ----------------------------------------
    ldr_byte_s  buf_q [2];
    ldr_byte_s  buf_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic       pop;
    logic       stall;

    // Ready follows the count only: a full buffer refuses even while it pops
    assign in_ready = (cnt_q != 2'h2);

    always_comb begin
        buf_d = buf_q;
        cnt_d = cnt_q;
        if (pop) begin
            buf_d[0] = buf_q[1];
            cnt_d    = cnt_d - 2'h1;
        end
        if (in_valid && in_ready) begin
            buf_d[cnt_d[0]] = in_byte;
            cnt_d           = cnt_d + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            cnt_q    <= 2'h0;
        end else begin
            buf_q <= buf_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] sy1_q, sy2_q;
    logic       fclk_prev_q;
    logic [2:0] strap;
    logic       frame_edge;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sy1_q       <= 4'h0;
            sy2_q       <= 4'h0;
            fclk_prev_q <= 1'b0;
        end else begin
            sy1_q       <= {frame_clk, strap_sub_bit_hi, strap_sub_bit_mid, strap_sub_bit_lo};
            sy2_q       <= sy1_q;
            fclk_prev_q <= sy2_q[3];
        end
    end

    // Straps are static but still pass two flops against metastability
    assign strap      = sy2_q[2:0];
    assign frame_edge = sy2_q[3] && !fclk_prev_q;
    // Display register load takes this cycle; byte waits one clock
    assign stall      = frame_edge;
    assign pop        = (cnt_q != 2'h0) && !stall;

    // ----------------------------------------
    // Command decode and RAM write
    // ----------------------------------------
    logic [3:0][79:0] ram_q, ram_d;
    ldr_mode_t        mode_q, mode_d;
    logic [6:0]       ptr_q, ptr_d;
    logic [2:0]       sub_q, sub_d;
    logic             ibank_q, ibank_d, obank_q, obank_d;
    logic             ack_q, ack_d, nack_q, nack_d;

    ldr_byte_s  cur;
    logic [2:0] per_col;
    logic [7:0] step;
    logic [7:0] col;
    logic [2:0] row;
    logic [1:0] rbase;
    logic [7:0] nxt;
    logic       spill;
    logic       drop;
    logic       hit;
    logic       dual_bank;

    assign dual_bank = (mode_q == `LDR_MODE_STAT) || (mode_q == `LDR_MODE_MUX2);

    always_comb begin
        cur     = buf_q[0];
        ram_d   = ram_q;
        mode_d  = mode_q;
        ptr_d   = ptr_q;
        sub_d   = sub_q;
        ibank_d = ibank_q;
        obank_d = obank_q;
        ack_d   = 1'b0;
        nack_d  = 1'b0;
        col     = 8'h00;
        row     = 3'h0;
        nxt     = 8'h00;
        spill   = 1'b0;
        drop    = 1'b0;
        hit     = 1'b0;
        // Rows per column and pointer step follow the drive mode
        case (mode_q)
            `LDR_MODE_STAT: begin
                per_col = 3'h1;
                step    = `LDR_INC_STAT;
            end
            `LDR_MODE_MUX2: begin
                per_col = 3'h2;
                step    = `LDR_INC_MUX2;
            end
            `LDR_MODE_MUX3: begin
                per_col = 3'h3;
                step    = `LDR_INC_MUX3;
            end
            default: begin
                per_col = 3'h4;
                step    = `LDR_INC_MUX4;
            end
        endcase
        rbase = (dual_bank && ibank_q) ? `LDR_BANK_OFS : 2'h0;
        if (pop) begin
            if (!cur.is_cmd) begin
                col = {1'b0, ptr_q};
                for (int j = 0; j < 8; j++) begin
                    if (col > {1'b0, `LDR_LAST_COL}) begin
                        spill = 1'b1;
                        if (sub_q + 3'h1 == strap) begin
                            ram_d[row[1:0] + rbase][7'(col - 8'(`LDR_NCOLS))] = cur.data[7 - j];
                            hit = 1'b1;
                        end
                    end else if (sub_q == strap) begin
                        ram_d[row[1:0] + rbase][col[6:0]] = cur.data[7 - j];
                        hit = 1'b1;
                    end
                    row = row + 3'h1;
                    if (row == per_col) begin
                        row = 3'h0;
                        col = col + 8'h01;
                    end
                end
                // Pointer moves even when this device stored nothing
                nxt = {1'b0, ptr_q} + step;
                if (nxt > {1'b0, `LDR_LAST_COL}) begin
                    nxt   = nxt - 8'(`LDR_NCOLS);
                    sub_d = sub_q + 3'h1;
                end
                ptr_d  = nxt[6:0];
                // Addressed last device: spilled bits fall off the end, no ack
                drop   = spill && cascade_last && (sub_q == strap);
                ack_d  = hit && !drop;
                nack_d = drop;
            end else if (!cur.data[7]) begin
                ptr_d = cur.data[6:0];
            end else if (cur.data[7:4] == `LDR_CMD_MODE) begin
                mode_d = cur.data[1:0];
            end else if (cur.data[7:3] == `LDR_CMD_DEV) begin
                sub_d = cur.data[2:0];
            end else if (cur.data[7:2] == `LDR_CMD_BANK && dual_bank) begin
                // Bank bits stay put in 1:3 and 1:4
                ibank_d = cur.data[1];
                obank_d = cur.data[0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ram_q   <= '0;
            mode_q  <= `LDR_MODE_STAT;
            ptr_q   <= 7'h00;
            sub_q   <= 3'h0;
            ibank_q <= 1'b0;
            obank_q <= 1'b0;
            ack_q   <= 1'b0;
            nack_q  <= 1'b0;
        end else begin
            ram_q   <= ram_d;
            mode_q  <= mode_d;
            ptr_q   <= ptr_d;
            sub_q   <= sub_d;
            ibank_q <= ibank_d;
            obank_q <= obank_d;
            ack_q   <= ack_d;
            nack_q  <= nack_d;
        end
    end

    assign drive_mode = mode_q;
    assign byte_ack   = ack_q;
    assign byte_nack  = nack_q;

    // ----------------------------------------
    // Readout sequencing
    // ----------------------------------------
    logic [1:0]  phase_q, phase_d;
    logic [1:0]  last_phase;
    logic [1:0]  out_row;
    logic [79:0] seg_q, seg_d;
    logic [3:0]  bp_q, bp_d;
    logic [3:0]  onehot;

    always_comb begin
        case (mode_q)
            `LDR_MODE_STAT: last_phase = 2'h0;
            `LDR_MODE_MUX2: last_phase = 2'h1;
            `LDR_MODE_MUX3: last_phase = 2'h2;
            default:        last_phase = 2'h3;
        endcase
        phase_d = phase_q;
        seg_d   = seg_q;
        bp_d    = bp_q;
        // Phase may exceed a mode shrunk mid-frame; wrap catches it
        out_row = (phase_q > last_phase) ? 2'h0 : phase_q;
        if (dual_bank && obank_q) begin
            out_row = out_row + `LDR_BANK_OFS;
        end
        onehot = 4'h1 << ((phase_q > last_phase) ? 2'h0 : phase_q);
        // Row and backplane pattern latch together so both switch on one edge
        if (frame_edge) begin
            phase_d = (phase_q >= last_phase) ? 2'h0 : phase_q + 2'h1;
            seg_d   = ram_q[out_row];
            case (mode_q)
                `LDR_MODE_STAT: bp_d = 4'hF;
                `LDR_MODE_MUX2: bp_d = {onehot[1], onehot[0], onehot[1:0]};
                `LDR_MODE_MUX3: bp_d = {onehot[1], onehot[2:0]};
                default:        bp_d = onehot;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 2'h0;
            seg_q   <= '0;
            bp_q    <= 4'h0;
        end else begin
            phase_q <= phase_d;
            seg_q   <= seg_d;
            bp_q    <= bp_d;
        end
    end

    assign segment_outputs                 = seg_q;
    assign backplanes.backplane_out_first  = bp_q[0];
    assign backplanes.backplane_out_second = bp_q[1];
    assign backplanes.backplane_out_third  = bp_q[2];
    assign backplanes.backplane_out_fourth = bp_q[3];

endmodule

/* src/ldr_pkg.sv */
package ldr_pkg;

    typedef struct packed {
        logic       is_cmd;
        logic [7:0] data;
    } ldr_byte_s;

    typedef logic [1:0] ldr_mode_t;

    typedef struct packed {
        logic backplane_out_first;
        logic backplane_out_second;
        logic backplane_out_third;
        logic backplane_out_fourth;
    } ldr_bp_s;

endpackage

/* verification/ldr_display_ram_monitor.sv */
`timescale 1ns/1ps
`include "ldr_defines.svh"
module ldr_display_ram_monitor
    import ldr_pkg::*;
(
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               in_valid,
    input wire logic               in_ready,
    input wire logic               frame_clk,
    input wire ldr_pkg::ldr_mode_t drive_mode,
    input wire logic               byte_ack,
    input wire logic               byte_nack,
    input wire ldr_pkg::ldr_bp_s   backplanes,
    input wire logic [79:0]        segment_outputs
);
    // ----
    // Helpers: phase edges since mode change, age of last edge and take
    // ----
    logic       fr_q;
    logic [1:0] fe_q, fe_d;
    logic [3:0] sf_q, sf_d, st_q, st_d;
    ldr_mode_t  md_q;
    logic       fe_ok;
    assign fe_ok = fe_q >= 2'h2 && drive_mode == md_q;
    always_comb begin
        fe_d = (drive_mode != md_q) ? 2'h0 : fe_q + {1'b0, frame_clk && !fr_q && fe_q != 2'h3};
        sf_d = (frame_clk && !fr_q) ? 4'h0 : sf_q + {3'h0, sf_q != 4'hF};
        st_d = (in_valid && in_ready) ? 4'h0 : st_q + {3'h0, st_q != 4'hF};
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fr_q <= 1'b0;
            md_q <= `LDR_MODE_STAT;
            fe_q <= 2'h0;
            sf_q <= 4'hF;
            st_q <= 4'hF;
        end else begin
            fr_q <= frame_clk;
            md_q <= drive_mode;
            fe_q <= fe_d;
            sf_q <= sf_d;
            st_q <= st_d;
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    static_bp_a: assert property (fe_ok && drive_mode == `LDR_MODE_STAT |->
        backplanes == {4{backplanes.backplane_out_first}}) else $error("static backplanes differ");
    mux2_bp_a: assert property (fe_ok && drive_mode == `LDR_MODE_MUX2 |->
        backplanes.backplane_out_third == backplanes.backplane_out_first &&
        backplanes.backplane_out_fourth == backplanes.backplane_out_second)
        else $error("duplex backplane pairs differ");
    mux3_bp_a: assert property (fe_ok && drive_mode == `LDR_MODE_MUX3 |->
        backplanes.backplane_out_fourth == backplanes.backplane_out_second)
        else $error("triplex fourth backplane differs");
    mux4_bp_a: assert property (fe_ok && drive_mode == `LDR_MODE_MUX4 |->
        $onehot(backplanes)) else $error("quad backplanes not one-hot");
    reset_vals_a: assert property ($rose(rstn) |-> in_ready && !byte_ack &&
        drive_mode == `LDR_MODE_STAT && segment_outputs == 80'h0) else $error("bad reset state");
    ack_excl_a: assert property (!(byte_ack && byte_nack)) else $error("ack with nack");
    ack_recent_a: assert property (byte_ack || byte_nack |-> st_q <= 4'hC)
        else $error("answer without a taken byte");
    frame_upd_a: assert property ($changed(segment_outputs) || $changed(backplanes) |->
        sf_q inside {[1:8]}) else $error("readout moved without phase edge");
    cover property (byte_nack);
    cover property (fe_ok && drive_mode == `LDR_MODE_MUX3);
    cover property (byte_ack ##1 byte_ack);
endmodule

bind ldr_display_ram ldr_display_ram_monitor mon (.clk(clk), .rstn(rstn), .in_valid(in_valid),
    .in_ready(in_ready), .frame_clk(frame_clk), .drive_mode(drive_mode), .byte_ack(byte_ack),
    .byte_nack(byte_nack), .backplanes(backplanes), .segment_outputs(segment_outputs));

/* verification/ldr_display_ram_test.sv */
`timescale 1ns/1ps
`include "ldr_defines.svh"
module ldr_display_ram_test;
    import ldr_pkg::*;
    logic        clk, rstn, cascade_last, in_valid, in_ready, frame_clk, byte_ack, byte_nack;
    logic [2:0]  strap;
    logic [79:0] seg;
    ldr_byte_s   in_byte;
    ldr_mode_t   drive_mode;
    ldr_bp_s     bp;
    int          n_errors = 0, n_checks = 0, n_ack = 0, n_nack = 0;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ldr_host_model host (.clk(clk), .in_ready(in_ready), .in_byte(in_byte),
        .in_valid(in_valid), .frame_clk(frame_clk));
    ldr_display_ram DUT (.clk(clk), .rstn(rstn), .in_byte(in_byte), .in_valid(in_valid),
        .in_ready(in_ready), .strap_sub_bit_lo(strap[0]), .strap_sub_bit_mid(strap[1]),
        .strap_sub_bit_hi(strap[2]), .cascade_last(cascade_last), .frame_clk(frame_clk),
        .drive_mode(drive_mode), .byte_ack(byte_ack), .byte_nack(byte_nack),
        .backplanes(bp), .segment_outputs(seg));
    always @(posedge clk) begin
        n_ack += (byte_ack === 1'b1);
        n_nack += (byte_nack === 1'b1);
    end

    task check(input logic [79:0] seen, input logic [79:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task settle;
        repeat (100) @(posedge clk);
        #1;
    endtask
    // Waits for a phase with backplane idx active (3 = first)
    task wait_row(input int idx);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (bp[idx] !== 1'b1 && n < 200);
        check(bp[idx], 1'b1);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        final_report;
    end
    initial begin
        rstn = 1'b0;
        cascade_last = 1'b0;
        strap = 3'h0;
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        @(posedge clk);
        #1;
        host.send({9'h1C1, 9'h100, 9'h0C1, 9'h0C1});
        settle;
        wait_row(3);
        check(seg[15:0], 16'h8383);
        check(n_ack, 2);
        $display("test static done");
        host.send({9'h1FA, 9'h100, 9'h0FF});
        settle;
        check(seg[7:0], 8'h83);
        host.send({9'h1F9});
        settle;
        check(seg[7:0], 8'hFF);
        $display("test banks done");
        host.send({9'h1F8, 9'h1E7, 9'h148, 9'h0FF, 9'h00F});
        settle;
        check(seg[7:0], 8'hF0);
        check(seg[79:72], 8'h00);
        host.send({9'h1E7, 9'h14E, 9'h03F});
        settle;
        check(seg[7:0], 8'hFF);
        check(n_ack, 5);
        $display("test cascade done");
        cascade_last = 1'b1;
        host.send({9'h1E0, 9'h14E, 9'h0C0});
        settle;
        check(seg[79:78], 2'h3);
        check({n_ack, n_nack}, {32'd5, 32'd1});
        $display("test last device done");
        host.send({9'h1C0, 9'h1E0, 9'h100, 9'h081});
        settle;
        check(drive_mode, `LDR_MODE_MUX4);
        wait_row(3);
        check(seg[1:0], 2'h1);
        wait_row(0);
        check(seg[1:0], 2'h2);
        host.send({9'h1C3, 9'h100, 9'h000});
        settle;
        wait_row(1);
        check(seg[2:0], 3'h4);
        host.send({9'h1F9, 9'h102, 9'h0C0});
        settle;
        wait_row(1);
        check(seg[2:0], 3'h0);
        wait_row(3);
        check(seg[2:0], 3'h4);
        host.send({9'h1C2, 9'h100, 9'h090});
        settle;
        wait_row(3);
        check(seg[3:0], 4'h1);
        wait_row(2);
        check(seg[3:0], 4'h2);
        $display("test multiplex done");
        final_report;
    end
endmodule

/* verification/ldr_host_model.sv */
`timescale 1ns/1ps
module ldr_host_model (
    input  wire logic          clk,
    input  wire logic          in_ready,
    output ldr_pkg::ldr_byte_s in_byte,
    output logic               in_valid,
    output logic               frame_clk
);
    import ldr_pkg::*;
    initial begin
        in_byte = '0;
        in_valid = 1'b0;
    end
    // Phase clock runs free, phase unrelated to clk
    initial begin
        frame_clk = 1'b0;
        #37;
        forever #80 frame_clk = ~frame_clk;
    end
    // Each byte held until an edge sees ready; no gap between bytes
    // A byte refused forever hangs here; the bench watchdog ends the run
    task automatic send(input logic [8:0] q[$]);
        foreach (q[i]) begin
            in_byte = ldr_byte_s'(q[i]);
            in_valid = 1'b1;
            do begin
                @(posedge clk);
            end while (!in_ready);
            #1;
        end
        in_valid = 1'b0;
    endtask
endmodule
